/* tas_pkg.sv */
// package for the activation signal select block, plus its per-state signal decoder
`default_nettype none

package tas_pkg;

  // register byte offsets
  localparam logic [7:0] TAS_OFS_CTRL   = 8'h00;
  localparam logic [7:0] TAS_OFS_CMD    = 8'h04;
  localparam logic [7:0] TAS_OFS_STATUS = 8'h08;
  localparam logic [7:0] TAS_OFS_HDR    = 8'h0C;

  // ctrl field positions and reset value
  localparam int         TAS_CTRL_REMOTE_BIT = 0;
  localparam logic [0:0] TAS_CTRL_RESET      = 1'h0;

  // status field positions
  localparam int TAS_ST_STATE_LSB  = 0;
  localparam int TAS_ST_DONE_BIT   = 4;
  localparam int TAS_ST_REFUSE_BIT = 5;
  localparam int TAS_ST_RAF_BIT    = 6;
  localparam int TAS_ST_SERVICE_RETURN_REQUEST_FLAG_BIT   = 7;
  localparam int TAS_ST_SIG_LSB    = 8;
  localparam int TAS_ST_IDLE_BIT   = 12;

  // header readback field positions
  localparam int TAS_HD_TRIG_BIT   = 0;
  localparam int TAS_HD_FLAG_BIT   = 1;
  localparam int TAS_HD_RAI_BIT    = 2;
  localparam int TAS_HD_IDLEOC_BIT = 3;
  localparam int TAS_HD_SILENT_BIT = 4;
  localparam int TAS_HD_UD_BIT     = 5;
  localparam int TAS_HD_EOC_BIT    = 6;
  localparam int TAS_HD_VOC_BIT    = 7;
  localparam int TAS_HD_OPT_BIT    = 8;
  localparam int TAS_HD_VLVL_BIT   = 9;

  // activation state codes as reported by the state machine
  localparam logic [2:0] TAS_S_POWERUP   = 3'h0;
  localparam logic [2:0] TAS_S_STANDBY   = 3'h1;
  localparam logic [2:0] TAS_S_CONVERGE  = 3'h2;
  localparam logic [2:0] TAS_S_FINDFRAME = 3'h3;
  localparam logic [2:0] TAS_S_ACTIVE    = 3'h4;
  localparam logic [2:0] TAS_S_RESYNC    = 3'h5;
  localparam logic [2:0] TAS_S_HANDSHAKE = 3'h6;

  // control signal command codes
  localparam logic [2:0] TAS_C_CONNECT    = 3'h1;
  localparam logic [2:0] TAS_C_QUIET      = 3'h2;
  localparam logic [2:0] TAS_C_CHANGE     = 3'h3;
  localparam logic [2:0] TAS_C_IDLE_REQ   = 3'h4;
  localparam logic [2:0] TAS_C_RESUME     = 3'h5;
  localparam logic [2:0] TAS_C_DISCONNECT = 3'h6;

  // transmit signal types
  typedef enum logic [1:0] {
    TAS_SIG_QUIET,
    TAS_SIG_ACQUIRE,
    TAS_SIG_TRIG,
    TAS_SIG_DATA
  } tas_sig_t;

endpackage : tas_pkg

// per-state transmit signal and traffic permissions, purely combinational
module tas_sig_map
  import tas_pkg::*;
(
  input  wire logic [2:0] state,
  input  wire logic       remote_side,
  input  wire logic       link_idle,
  output tas_sig_t        sig,
  output logic            silent,
  output logic            trig,
  output logic            idle_oc,
  output logic            rai_fixed,
  output logic            ud_allow,
  output logic            eoc_allow,
  output logic            voc_allow,
  output logic            optional_traffic,
  output logic            var_level
);

  // one signal type per state; unknown codes fall to silence as the safe choice
  always_comb begin
    case (state)
      TAS_S_POWERUP, TAS_S_STANDBY:   sig = TAS_SIG_QUIET;   // [R7]
      TAS_S_CONVERGE, TAS_S_FINDFRAME: sig = TAS_SIG_ACQUIRE; // [R7]
      TAS_S_HANDSHAKE:                sig = TAS_SIG_TRIG;    // [R7]
      TAS_S_ACTIVE, TAS_S_RESYNC:     sig = TAS_SIG_DATA;    // [R7] [R19]
      default:                        sig = TAS_SIG_QUIET;
    endcase
  end

  assign silent           = (sig == TAS_SIG_QUIET);                       // [R8]
  assign trig             = (sig == TAS_SIG_TRIG);                        // [R12] [R13]
  assign idle_oc          = (sig == TAS_SIG_ACQUIRE) || (sig == TAS_SIG_TRIG); // [R11]
  assign rai_fixed        = (sig == TAS_SIG_ACQUIRE);                     // [R15]
  assign ud_allow         = (sig == TAS_SIG_TRIG) || (sig == TAS_SIG_DATA); // [R16]
  assign eoc_allow        = (sig == TAS_SIG_DATA);                        // [R17]
  assign voc_allow        = (sig == TAS_SIG_DATA);                        // [R17]
  assign optional_traffic = link_idle && ud_allow;                        // [R16] [R17]
  assign var_level        = remote_side && (sig == TAS_SIG_ACQUIRE);      // [R18]

endmodule : tas_sig_map

`default_nettype wire

/* tas_select.sv */
// transmit signal select, header bits and management flags with an apb register slave
// Operation
// [R1] state indicator always shows the current activation state
// [R2] management uses the state to gate user data and embedded channel
// [R3] done flag set when the latest command was carried out
// [R4] refused flag set when the latest command could not be carried out
// [R5] office side flags remote activation request, meaningful only in standby
// [R6] office side flags service return request, only while the link is idle
// [R7] each state selects exactly one transmit signal type
// [R8] silence signals drive zero and send no frames
// [R9] non-silent signals go out as frames with overhead, trigger, flag, alarm bits
// [R10] remote alarm is frame loss or remote failure
// [R11] acquire and trigger carry idle overhead; data may carry valid messages
// [R12] office trigger bit is one only in the office trigger signal
// [R13] remote trigger bit is one only in the remote trigger signal
// [R14] remote service bit is one in data once resume was applied remotely
// [R15] alarm bit is one during that side's acquire signal
// [R16] user data denied in acquire, allowed in trigger and data, optional when idle
// [R17] embedded channel only in data, optional when idle; overhead allowed in data
// [R18] remote acquire enables variable transmit level for power back-off
// [R19] office active state sends data whether steady or idle
// [R20] resume service control only applies while the link is idle
// [R21] a new command clears both outcome flags
`default_nettype none

module tas_select
  import tas_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [2:0]  sm_state,
  input  wire logic        link_idle,
  input  wire logic        cmd_ack,
  input  wire logic        cmd_nak,
  input  wire logic        peer_activation_req,
  input  wire logic        peer_service_req,
  input  wire logic        frame_loss_indication,
  input  wire logic        remote_failure_indication,
  output logic             cmd_valid,
  output logic [2:0]       cmd_code,
  output logic [2:0]       state_indicator,
  output logic [1:0]       tx_signal,
  output logic             tx_silent,
  output logic             hdr_trig,
  output logic             hdr_service_req,
  output logic             hdr_rai,
  output logic             hdr_idle_overhead,
  output logic             user_data_allow,
  output logic             eoc_allow,
  output logic             link_overhead_message_channel_allow,
  output logic             traffic_optional,
  output logic             var_level_en,
  output logic             command_done_flag,
  output logic             command_refused_flag,
  output logic             remote_activation_request_flag,
  output logic             service_return_request_flag
);

  // decoded per-state view
  tas_sig_t m_sig;
  logic     m_silent;
  logic     m_trig;
  logic     m_idle_oc;
  logic     m_rai;
  logic     m_ud;
  logic     m_eoc;
  logic     m_voc;
  logic     m_opt;
  logic     m_vlvl;

  // control register and held state
  logic       remote_side;
  logic       resume_applied;
  logic       cmd_pending;
  logic [2:0] last_cmd;
  logic       next_remote_side;
  logic       next_resume_applied;
  logic       next_cmd_pending;
  logic [2:0] next_last_cmd;
  logic       next_cmd_valid;
  logic [2:0] next_cmd_code;
  logic       next_done;
  logic       next_refused;
  logic       next_raf;
  logic       next_service_return_request_flag;

  // registered line-facing outputs
  logic [2:0] next_state_ind;
  logic [1:0] next_tx_signal;
  logic       next_silent;
  logic       next_trig;
  logic       next_svc;
  logic       next_rai;
  logic       next_idle_oc;
  logic       next_ud;
  logic       next_eoc;
  logic       next_voc;
  logic       next_opt;
  logic       next_vlvl;

  // bus answer
  logic        next_pready;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        wr_ctrl;
  logic        wr_cmd;
  logic        wr_status;
  logic        access;

  // true when the byte address hits one of the four words
  function automatic logic tas_mapped(input logic [7:0] a);
    tas_mapped = (a == TAS_OFS_CTRL) || (a == TAS_OFS_CMD) ||
                 (a == TAS_OFS_STATUS) || (a == TAS_OFS_HDR);
  endfunction : tas_mapped

  tas_sig_map u_map (
    .state            (sm_state),
    .remote_side      (remote_side),
    .link_idle        (link_idle),
    .sig              (m_sig),
    .silent           (m_silent),
    .trig             (m_trig),
    .idle_oc          (m_idle_oc),
    .rai_fixed        (m_rai),
    .ud_allow         (m_ud),
    .eoc_allow        (m_eoc),
    .voc_allow        (m_voc),
    .optional_traffic (m_opt),
    .var_level        (m_vlvl)
  );

  // a write takes effect on the first access cycle, the wait state before pready is raised
  assign access    = psel && penable && !pready;
  assign wr_ctrl   = access && pwrite && (paddr == TAS_OFS_CTRL);
  assign wr_cmd    = access && pwrite && (paddr == TAS_OFS_CMD);
  assign wr_status = access && pwrite && (paddr == TAS_OFS_STATUS);

  // command issue, outcome flags and request flags
  always_comb begin
    next_remote_side    = remote_side;
    next_resume_applied = resume_applied;
    next_cmd_pending    = cmd_pending;
    next_last_cmd       = last_cmd;
    next_cmd_valid      = 1'b0;
    next_cmd_code       = cmd_code;
    next_done           = command_done_flag;
    next_refused        = command_refused_flag;
    next_raf            = remote_activation_request_flag;
    next_service_return_request_flag           = service_return_request_flag;
    if (wr_ctrl) begin
      next_remote_side = pwdata[TAS_CTRL_REMOTE_BIT];
    end
    if (wr_cmd) begin
      next_last_cmd = pwdata[2:0];
      next_done     = 1'b0; // [R21]
      next_refused  = 1'b0; // [R21]
      if (pwdata[2:0] == TAS_C_RESUME && !link_idle) begin
        next_refused     = 1'b1; // [R4] [R20]
        next_cmd_pending = 1'b0;
      end else if (pwdata[2:0] == TAS_C_CONNECT && sm_state != TAS_S_STANDBY) begin
        next_refused     = 1'b1; // [R4]
        next_cmd_pending = 1'b0;
      end else begin
        next_cmd_valid   = 1'b1;
        next_cmd_code    = pwdata[2:0];
        next_cmd_pending = 1'b1;
        if (pwdata[2:0] == TAS_C_RESUME && remote_side) begin
          next_resume_applied = 1'b1; // [R14] [R20]
        end
      end
    end else if (cmd_pending && cmd_ack) begin
      next_done        = 1'b1; // [R3]
      next_cmd_pending = 1'b0;
    end else if (cmd_pending && cmd_nak) begin
      next_refused     = 1'b1; // [R4]
      next_cmd_pending = 1'b0;
    end
    // remote service bit lasts only through the data signal of this resume
    if (m_sig != TAS_SIG_DATA) begin
      next_resume_applied = 1'b0;
    end
    // request flags: write one clears, a fresh request in the same cycle wins
    if (wr_status && pwdata[TAS_ST_RAF_BIT]) begin
      next_raf = 1'b0;
    end
    if (wr_status && pwdata[TAS_ST_SERVICE_RETURN_REQUEST_FLAG_BIT]) begin
      next_service_return_request_flag = 1'b0;
    end
    if (remote_side || sm_state != TAS_S_STANDBY) begin
      next_raf = 1'b0; // [R5]
    end else if (peer_activation_req) begin
      next_raf = 1'b1; // [R5]
    end
    if (remote_side || !link_idle) begin
      next_service_return_request_flag = 1'b0; // [R6]
    end else if (peer_service_req) begin
      next_service_return_request_flag = 1'b1; // [R6]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remote_side                    <= TAS_CTRL_RESET;
      resume_applied                 <= 1'b0;
      cmd_pending                    <= 1'b0;
      last_cmd                       <= 3'h0;
      cmd_valid                      <= 1'b0;
      cmd_code                       <= 3'h0;
      command_done_flag              <= 1'b0;
      command_refused_flag           <= 1'b0;
      remote_activation_request_flag <= 1'b0;
      service_return_request_flag    <= 1'b0;
    end else begin
      remote_side                    <= next_remote_side;
      resume_applied                 <= next_resume_applied;
      cmd_pending                    <= next_cmd_pending;
      last_cmd                       <= next_last_cmd;
      cmd_valid                      <= next_cmd_valid;
      cmd_code                       <= next_cmd_code;
      command_done_flag              <= next_done;
      command_refused_flag           <= next_refused;
      remote_activation_request_flag <= next_raf;
      service_return_request_flag    <= next_service_return_request_flag;
    end
  end

  // header bits and permissions; all but the state indicator and tx_silent are low under silence
  always_comb begin
    next_state_ind = sm_state; // [R1]
    next_tx_signal = m_sig;    // [R7]
    next_silent    = m_silent; // [R8]
    next_trig      = !m_silent && m_trig; // [R9] [R12] [R13]
    next_svc       = !m_silent && remote_side && (m_sig == TAS_SIG_DATA)
                     && resume_applied; // [R14]
    // the fixed acquire value is kept and live alarms are folded on top
    next_rai       = !m_silent && (m_rai || frame_loss_indication
                     || remote_failure_indication); // [R10] [R15]
    next_idle_oc   = !m_silent && m_idle_oc; // [R11]
    next_ud        = m_ud;   // [R16] [R2]
    next_eoc       = m_eoc;  // [R17]
    next_voc       = m_voc;  // [R17]
    next_opt       = m_opt;  // [R16] [R17]
    next_vlvl      = m_vlvl; // [R18]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_indicator                     <= TAS_S_POWERUP;
      tx_signal                           <= 2'h0;
      tx_silent                           <= 1'b1;
      hdr_trig                            <= 1'b0;
      hdr_service_req                     <= 1'b0;
      hdr_rai                             <= 1'b0;
      hdr_idle_overhead                   <= 1'b0;
      user_data_allow                     <= 1'b0;
      eoc_allow                           <= 1'b0;
      link_overhead_message_channel_allow <= 1'b0;
      traffic_optional                    <= 1'b0;
      var_level_en                        <= 1'b0;
    end else begin
      state_indicator                     <= next_state_ind;
      tx_signal                           <= next_tx_signal;
      tx_silent                           <= next_silent;
      hdr_trig                            <= next_trig;
      hdr_service_req                     <= next_svc;
      hdr_rai                             <= next_rai;
      hdr_idle_overhead                   <= next_idle_oc;
      user_data_allow                     <= next_ud;
      eoc_allow                           <= next_eoc;
      link_overhead_message_channel_allow <= next_voc;
      traffic_optional                    <= next_opt;
      var_level_en                        <= next_vlvl;
    end
  end

  // apb answer: one wait state, so read data is registered like every output
  always_comb begin
    next_pready  = access;
    next_pslverr = access && !tas_mapped(paddr);
    next_prdata  = 32'h0;
    if (access && !pwrite) begin
      case (paddr)
        TAS_OFS_CTRL: begin
          next_prdata[TAS_CTRL_REMOTE_BIT] = remote_side;
        end
        TAS_OFS_CMD: begin
          next_prdata[2:0] = last_cmd;
        end
        TAS_OFS_STATUS: begin
          next_prdata[TAS_ST_STATE_LSB +: 3] = state_indicator;
          next_prdata[TAS_ST_DONE_BIT]       = command_done_flag;
          next_prdata[TAS_ST_REFUSE_BIT]     = command_refused_flag;
          next_prdata[TAS_ST_RAF_BIT]        = remote_activation_request_flag;
          next_prdata[TAS_ST_SERVICE_RETURN_REQUEST_FLAG_BIT]       = service_return_request_flag;
          next_prdata[TAS_ST_SIG_LSB +: 2]   = tx_signal;
          next_prdata[TAS_ST_IDLE_BIT]       = link_idle;
        end
        TAS_OFS_HDR: begin
          next_prdata[TAS_HD_TRIG_BIT]   = hdr_trig;
          next_prdata[TAS_HD_FLAG_BIT]   = hdr_service_req;
          next_prdata[TAS_HD_RAI_BIT]    = hdr_rai;
          next_prdata[TAS_HD_IDLEOC_BIT] = hdr_idle_overhead;
          next_prdata[TAS_HD_SILENT_BIT] = tx_silent;
          next_prdata[TAS_HD_UD_BIT]     = user_data_allow;
          next_prdata[TAS_HD_EOC_BIT]    = eoc_allow;
          next_prdata[TAS_HD_VOC_BIT]    = link_overhead_message_channel_allow;
          next_prdata[TAS_HD_OPT_BIT]    = traffic_optional;
          next_prdata[TAS_HD_VLVL_BIT]   = var_level_en;
        end
        default: begin
          next_prdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule : tas_select

`default_nettype wire

/* tas_select_properties.sv */
// concurrent checks on the transmit signal select block ports
`default_nettype none

module tas_select_properties
  import tas_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic [2:0] sm_state,
  input wire logic       link_idle,
  input wire logic       frame_loss_indication,
  input wire logic       remote_failure_indication,
  input wire logic       cmd_valid,
  input wire logic [2:0] state_indicator,
  input wire logic [1:0] tx_signal,
  input wire logic       tx_silent,
  input wire logic       hdr_trig,
  input wire logic       hdr_rai,
  input wire logic       user_data_allow,
  input wire logic       eoc_allow,
  input wire logic       traffic_optional,
  input wire logic       command_done_flag,
  input wire logic       command_refused_flag,
  input wire logic       remote_activation_request_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // signal type per state; resync keeps the data signal of the active state
  function automatic logic [1:0] want_sig(input logic [2:0] s);
    case (s)
      TAS_S_CONVERGE, TAS_S_FINDFRAME: return TAS_SIG_ACQUIRE;
      TAS_S_ACTIVE, TAS_S_RESYNC: return TAS_SIG_DATA;
      TAS_S_HANDSHAKE: return TAS_SIG_TRIG;
      default: return TAS_SIG_QUIET;
    endcase
  endfunction : want_sig

  state_copy_a: assert property (state_indicator == $past(sm_state))
    else $error("state indicator wrong");
  signal_pick_a: assert property (tx_signal == want_sig($past(sm_state)))
    else $error("tx signal wrong");
  trig_bit_a: assert property (hdr_trig == (tx_signal == TAS_SIG_TRIG))
    else $error("trigger bit wrong");
  alarm_or_a: assert property (hdr_rai == (tx_signal == TAS_SIG_ACQUIRE ||
    (!tx_silent && $past(frame_loss_indication || remote_failure_indication))))
    else $error("alarm bit wrong");
  traffic_gate_a: assert property (user_data_allow == (tx_signal inside
    {TAS_SIG_TRIG, TAS_SIG_DATA}) && eoc_allow == (tx_signal == TAS_SIG_DATA))
    else $error("traffic permission wrong");
  optional_a: assert property (traffic_optional == ($past(link_idle) && user_data_allow))
    else $error("optional traffic wrong");
  outcome_one_a: assert property (!(command_done_flag && command_refused_flag))
    else $error("both outcome flags set");
  new_cmd_clear_a: assert property (cmd_valid |->
    !command_done_flag && !command_refused_flag) else $error("outcome not cleared");
  raf_standby_a: assert property (remote_activation_request_flag |->
    $past(sm_state) == TAS_S_STANDBY) else $error("activation flag outside standby");
  apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
endmodule : tas_select_properties

bind tas_select tas_select_properties i_props (.*);

`default_nettype wire

/* tas_peer_model.sv */
// stand-in for the state machine and far end that answer forwarded commands
`default_nettype none

module tas_peer_model
  import tas_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       cmd_valid,
  input  wire logic [2:0] cmd_code,
  input  wire logic       link_idle,
  input  wire logic       refuse,
  input  wire logic       slow,
  output logic            cmd_ack,
  output logic            cmd_nak
);
  logic       busy;
  logic [2:0] wait_cnt;

  // one command at a time, answered promptly or after a few cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy     <= 1'b0;
      wait_cnt <= 3'h0;
      cmd_ack  <= 1'b0;
      cmd_nak  <= 1'b0;
    end else begin
      cmd_ack <= 1'b0;
      cmd_nak <= 1'b0;
      if (cmd_valid) begin
        busy     <= 1'b1;
        wait_cnt <= slow ? 3'h6 : 3'h0;
      end else if (busy && wait_cnt != 3'h0) begin
        wait_cnt <= wait_cnt - 3'h1;
      end else if (busy) begin
        busy <= 1'b0;
        // resume only moves the link out of idle
        if (refuse || (cmd_code == TAS_C_RESUME && !link_idle)) begin
          cmd_nak <= 1'b1;
        end else begin
          cmd_ack <= 1'b1;
        end
      end
    end
  end
endmodule : tas_peer_model

`default_nettype wire

/* test_transceiver_activation_signal_select.sv */
// self-checking bench for the transmit signal select block
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end

module test_transceiver_activation_signal_select
  import tas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, link_idle, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  sm_state, cmd_code, state_indicator;
  logic [1:0]  tx_signal;
  logic        cmd_ack, cmd_nak, peer_activation_req, peer_service_req, refuse, slow;
  logic        frame_loss_indication, remote_failure_indication, cmd_valid, tx_silent;
  logic        hdr_trig, hdr_service_req, hdr_rai, hdr_idle_overhead, user_data_allow;
  logic        eoc_allow, link_overhead_message_channel_allow, traffic_optional, var_level_en;
  logic        command_done_flag, command_refused_flag, remote_activation_request_flag;
  logic        service_return_request_flag;
  int          mismatches, compares;
  int          cmd_seen = 0;

  tas_select     i_dut  (.*);
  tas_peer_model i_peer (.*);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // count forwarded commands
  always @(posedge pclk) if (cmd_valid === 1'b1) cmd_seen <= cmd_seen + 1;

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic complete_run;
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // one apb transfer; an extra edge after release keeps drives one per time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      complete_run();
    end
    @(posedge pclk);
  endtask : apb

  // line outputs expected for state s, worked out from the signal table
  task automatic line_check(input logic [2:0] s, input logic rem, input logic idl);
    tas_sig_t sg;
    logic     acq, trg, dat;
    case (s)
      TAS_S_CONVERGE, TAS_S_FINDFRAME: sg = TAS_SIG_ACQUIRE;
      TAS_S_ACTIVE, TAS_S_RESYNC: sg = TAS_SIG_DATA;
      TAS_S_HANDSHAKE: sg = TAS_SIG_TRIG;
      default: sg = TAS_SIG_QUIET;
    endcase
    acq = (sg == TAS_SIG_ACQUIRE);
    trg = (sg == TAS_SIG_TRIG);
    dat = (sg == TAS_SIG_DATA);
    `CHK("state_indicator", s, state_indicator)
    `CHK("tx_signal", 2'(sg), tx_signal)
    `CHK("tx_silent", sg == TAS_SIG_QUIET, tx_silent)
    `CHK("hdr_trig", trg, hdr_trig)
    `CHK("hdr_rai", acq, hdr_rai)
    `CHK("hdr_idle_overhead", acq | trg, hdr_idle_overhead)
    `CHK("user_data_allow", trg | dat, user_data_allow)
    `CHK("eoc_allow", dat, eoc_allow)
    `CHK("voc_allow", dat, link_overhead_message_channel_allow)
    `CHK("traffic_optional", idl & (trg | dat), traffic_optional)
    `CHK("var_level_en", rem & acq, var_level_en)
  endtask : line_check

  initial begin
    {psel, penable, pwrite, paddr, pwdata, sm_state, link_idle} = '0;
    {peer_activation_req, peer_service_req, refuse, slow} = '0;
    {frame_loss_indication, remote_failure_indication} = '0;
    {mismatches, compares} = '0;
    presetn = 1'b0;
    cyc(4);
    presetn <= 1'b1;
    cyc(1);
    // reset values and an unmapped address
    apb(1'b0, TAS_OFS_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h0, rd)
    apb(1'b0, TAS_OFS_HDR, 32'h0);
    `CHK("hdr reset", 32'h1 << TAS_HD_SILENT_BIT, rd)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    // every state code on both ends, each state steady on one end and idle on the other
    for (int rem = 0; rem < 2; rem++) begin
      apb(1'b1, TAS_OFS_CTRL, 32'(rem));
      for (int s = 0; s < 8; s++) begin
        sm_state  <= 3'(s);
        link_idle <= s[0] ^ rem[0];
        cyc(2);
        line_check(3'(s), rem[0], s[0] ^ rem[0]);
      end
    end
    // live alarm sources only show on framed signals
    sm_state              <= TAS_S_ACTIVE;
    frame_loss_indication <= 1'b1;
    cyc(2);
    `CHK("rai frame_loss_indication", 1'b1, hdr_rai)
    frame_loss_indication     <= 1'b0;
    remote_failure_indication <= 1'b1;
    sm_state                  <= TAS_S_POWERUP;
    cyc(2);
    `CHK("rai silent", 1'b0, hdr_rai)
    remote_failure_indication <= 1'b0;
    // every command code accepted, prompt and slow answers
    apb(1'b1, TAS_OFS_CTRL, 32'h0);
    sm_state  <= TAS_S_STANDBY;
    link_idle <= 1'b1;
    for (int c = 1; c < 7; c++) begin
      slow <= c[0];
      apb(1'b1, TAS_OFS_CMD, 32'(c));
      cyc(10);
      `CHK("cmd count", c, cmd_seen)
      `CHK("cmd code", c, cmd_code)
      `CHK("done flag", 1'b1, command_done_flag)
    end
    // local refusals clear the old outcome and forward nothing
    sm_state  <= TAS_S_ACTIVE;
    link_idle <= 1'b0;
    apb(1'b1, TAS_OFS_CMD, {29'h0, TAS_C_CONNECT});
    cyc(3);
    `CHK("done cleared", 1'b0, command_done_flag)
    `CHK("refused connect", 1'b1, command_refused_flag)
    apb(1'b1, TAS_OFS_CMD, {29'h0, TAS_C_RESUME});
    cyc(3);
    `CHK("refused resume", 1'b1, command_refused_flag)
    `CHK("nothing forwarded", 6, cmd_seen)
    refuse <= 1'b1;
    apb(1'b1, TAS_OFS_CMD, {29'h0, TAS_C_QUIET});
    cyc(10);
    refuse <= 1'b0;
    `CHK("peer refusal", 1'b1, command_refused_flag)
    apb(1'b0, TAS_OFS_STATUS, 32'h0);
    `CHK("status", 32'h324, rd)
    // remote end raises the service bit after an accepted resume
    apb(1'b1, TAS_OFS_CTRL, 32'h1);
    link_idle <= 1'b1;
    apb(1'b1, TAS_OFS_CMD, {29'h0, TAS_C_RESUME});
    cyc(10);
    `CHK("service bit", 1'b1, hdr_service_req)
    sm_state <= TAS_S_HANDSHAKE;
    cyc(2);
    `CHK("service bit off", 1'b0, hdr_service_req)
    // office request flags, write-one-to-clear and forced off
    apb(1'b1, TAS_OFS_CTRL, 32'h0);
    sm_state            <= TAS_S_STANDBY;
    peer_activation_req <= 1'b1;
    peer_service_req    <= 1'b1;
    cyc(1);
    peer_activation_req <= 1'b0;
    peer_service_req    <= 1'b0;
    cyc(2);
    `CHK("raf set", 1'b1, remote_activation_request_flag)
    `CHK("service_return_request_flag set", 1'b1, service_return_request_flag)
    apb(1'b1, TAS_OFS_STATUS, 32'h1 << TAS_ST_RAF_BIT);
    `CHK("raf cleared", 1'b0, remote_activation_request_flag)
    link_idle           <= 1'b0;
    sm_state            <= TAS_S_CONVERGE;
    peer_activation_req <= 1'b1;
    cyc(2);
    `CHK("service_return_request_flag off", 1'b0, service_return_request_flag)
    `CHK("raf off", 1'b0, remote_activation_request_flag)
    complete_run();
  end
endmodule : test_transceiver_activation_signal_select

`default_nettype wire
